//--- design/lpd_params.svh
// constants for the loop converter code and mode control block
// assumes it is included by bare name from the design files
`ifndef LPD_PARAMS_SVH
`define LPD_PARAMS_SVH

// serial frame layout, msb first
`define LPD_FRAME_BITS      5'h18
`define LPD_CMD_MSB         23
`define LPD_CMD_LSB         16
`define LPD_DATA_MSB        15
`define LPD_DATA_LSB        0

// command byte values handled by this block
`define LPD_CMD_WR_CODE     8'h01
`define LPD_CMD_WR_MODE     8'h02
`define LPD_CMD_RD_CODE     8'h81
`define LPD_CMD_RD_MODE     8'h82

// reset values
`define LPD_CODE_RESET      16'h0000
`define LPD_MODE_RESET      16'h0000
`define LPD_RB_RESET        24'h00_0000

// mode control field positions
`define LPD_WD_SEL_MSB      15
`define LPD_WD_SEL_LSB      13
`define LPD_WD_EN_BIT       12
`define LPD_NO_AUTO_RB_BIT  11
`define LPD_ALARM_EN_BIT    10
`define LPD_MIN_LOOP_BIT    9
`define LPD_ADC_INSEL_BIT   8
`define LPD_ADC_EN_BIT      7
`define LPD_REF_PD_BIT      6
`define LPD_LOOPV_ALERT_BIT 5
`define LPD_MODE_LIVE_MASK  16'hffe0

// range bottom and span of each output range, in nanoamps
`define LPD_BASE_NARROW     25'h03d_0900
`define LPD_SPAN_NARROW     25'h0f4_2400
`define LPD_BASE_MIDDLE     25'h039_fbc0
`define LPD_SPAN_MIDDLE     25'h106_7380
`define LPD_BASE_WIDE       25'h030_d400
`define LPD_SPAN_WIDE       25'h13d_6200
`define LPD_CODE_SHIFT      16

`endif

//--- design/lpd_pkg.sv
// types shared by the loop converter block
// assumes lpd_params.svh is compiled alongside
package lpd_pkg;
  // output range as selected on the range pins
  typedef enum logic [1:0] {
    LPD_RANGE_NARROW = 2'h0,
    LPD_RANGE_MIDDLE = 2'h1,
    LPD_RANGE_WIDE   = 2'h2,
    LPD_RANGE_WIDE_B = 2'h3
  } lpd_range_e;

  typedef logic [15:0] lpd_word_t;
  typedef logic [24:0] lpd_current_t;
endpackage

//--- design/lpd_loop_map.sv
// ideal code to loop current mapping, result in nanoamps
// assumes code and range are already in the i_clock domain
`include "lpd_params.svh"

module lpd_loop_map (
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  // code and range
  input  wire logic [15:0]       i_code,
  input  wire lpd_pkg::lpd_range_e i_range,
  // ideal loop current
  output logic      [24:0]       o_current
);

  logic [24:0] base;
  logic [24:0] span;
  logic [40:0] product;
  logic [24:0] current_next;
  logic [24:0] current_reg;

  // range table; both wide encodings share the widest range
  assign base = (i_range == lpd_pkg::LPD_RANGE_NARROW) ? `LPD_BASE_NARROW :
                (i_range == lpd_pkg::LPD_RANGE_MIDDLE) ? `LPD_BASE_MIDDLE :
                `LPD_BASE_WIDE;
  assign span = (i_range == lpd_pkg::LPD_RANGE_NARROW) ? `LPD_SPAN_NARROW :
                (i_range == lpd_pkg::LPD_RANGE_MIDDLE) ? `LPD_SPAN_MIDDLE :
                `LPD_SPAN_WIDE;

  // span times code over 2^16: code 0 at bottom, 0x8000 mid, 0xffff one step short
  assign product = {16'h0000, span} * {25'h000_0000, i_code};
  assign current_next = base + product[40:16];

  // registered so the output comes straight from a flop; range is read every cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      current_reg <= 25'h000_0000;
    end else begin
      current_reg <= current_next;
    end
  end

  assign o_current = current_reg;

endmodule

//--- design/lpd_core.sv
// converter code and mode control registers behind a 24-bit serial frame
// assumes the host keeps frame select high for at least 4 i_clock cycles between frames
//
// Overview of operation
// - the converter code register is written and read over the serial frame and sets the loop current.
// - the converter code register is one unsigned 16-bit field, bit 15 most significant.
// - the narrowest range gives 4 mA plus code times 16 mA over 65536.
// - the middle range gives 3.8 mA plus code times 17.2 mA over 65536.
// - the widest range gives 3.2 mA plus code times 20.8 mA over 65536.
// - code 0x0000 lands at range bottom, 0x8000 at mid-span and 0xffff one step under full span.
// - a 16-bit mode control register is written and read back and selects the operating mode.
// - mode bits 15..13 are the watchdog period select, bit 12 watchdog enable, bit 11 auto readback control.
// - mode bits 10..5 are alarm, minimum current, adc select, adc enable, reference power down, loop alert; 4..0 reserved.
// - a 24-bit msb-first frame is shifted in while frame select is low and applied when it rises.
// - with bit 11 set a read command returns the addressed register on the serial output in the next frame.
`include "lpd_params.svh"

module lpd_core (
  // core clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // serial link, clocked by the host
  input  wire logic        i_serial_clock,
  input  wire logic        i_frame_sel_n,
  input  wire logic        i_serial_in,
  output logic             o_serial_out,
  // range select pins
  input  wire logic [1:0]  i_range_sel,
  // register contents and ideal loop current
  output logic [15:0]      o_converter_code,
  output logic [15:0]      o_mode_control,
  output logic [1:0]       o_range_active,
  output logic [24:0]      o_loop_current_value
);

  // link domain state
  logic        link_clear;
  logic [23:0] in_shift_reg;
  logic [4:0]  in_count_reg;
  logic [4:0]  in_count_step;
  logic        in_started_reg;
  logic [4:0]  out_count_reg;
  logic        out_bit_reg;
  logic [4:0]  out_index;

  // core domain state
  logic        sel_meta_reg;
  logic        sel_sync_reg;
  logic        sel_prev_reg;
  logic [1:0]  range_meta_reg;
  logic [1:0]  range_sync_reg;
  logic [1:0]  range_reg;
  logic [15:0] code_reg;
  logic [15:0] code_next;
  logic [15:0] mode_reg;
  logic [15:0] mode_next;
  logic [23:0] rb_word_reg;
  logic [23:0] rb_word_next;

  // decode of the captured frame
  logic        frame_end;
  logic        frame_full;
  logic        frame_take;
  logic [7:0]  cmd_byte;
  logic [15:0] data_word;
  logic        wr_code;
  logic        wr_mode;
  logic        rd_code;
  logic        rd_mode;
  logic        rb_enabled;

  // link start flag and readback output are held cleared while no frame runs, since the host clock may stand still
  assign link_clear = i_rst | i_frame_sel_n;

  // frame start flag; cleared by select high so the first falling edge restarts the count
  always_ff @(negedge i_serial_clock or posedge link_clear) begin
    if (link_clear) begin
      in_started_reg <= 1'b0;
    end else begin
      in_started_reg <= 1'b1;
    end
  end

  // count restarts at 1 on a frame's first edge and saturates past a full frame
  assign in_count_step = ~in_started_reg ? 5'h01 :
                         (in_count_reg == 5'h1f) ? in_count_reg : in_count_reg + 5'h01;

  // shift in on falling serial clock edges, msb first; not cleared by select high,
  // so the captured frame stays frozen while the core domain picks it up
  always_ff @(negedge i_serial_clock or posedge i_rst) begin
    if (i_rst) begin
      in_shift_reg <= 24'h00_0000;
      in_count_reg <= 5'h00;
    end else begin
      in_shift_reg <= {in_shift_reg[22:0], i_serial_in};
      in_count_reg <= in_count_step;
    end
  end

  // readback bits go out on rising edges so the host can take them on the falling edge
  assign out_index = 5'h17 - out_count_reg;

  // rb_word_reg is quiet during a frame: it only changes after frame select has risen
  always_ff @(posedge i_serial_clock or posedge link_clear) begin
    if (link_clear) begin
      out_bit_reg   <= 1'b0;
      out_count_reg <= 5'h00;
    end else begin
      if (out_count_reg < `LPD_FRAME_BITS) begin
        out_bit_reg   <= rb_word_reg[out_index];
        out_count_reg <= out_count_reg + 5'h01;
      end else begin
        out_bit_reg   <= 1'b0;
      end
    end
  end

  assign o_serial_out = out_bit_reg;

  // two flops on frame select and three on the range pins before any logic reads them
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sel_meta_reg   <= 1'b1;
      sel_sync_reg   <= 1'b1;
      sel_prev_reg   <= 1'b1;
      range_meta_reg <= 2'h0;
      range_sync_reg <= 2'h0;
      range_reg      <= 2'h0;
    end else begin
      sel_meta_reg   <= i_frame_sel_n;
      sel_sync_reg   <= sel_meta_reg;
      sel_prev_reg   <= sel_sync_reg;
      range_meta_reg <= i_range_sel;
      range_sync_reg <= range_meta_reg;
      range_reg      <= range_sync_reg;
    end
  end

  // rising frame select seen in the core domain; the shift register is frozen by then
  assign frame_end  = sel_sync_reg & ~sel_prev_reg;
  assign frame_full = (in_count_reg == `LPD_FRAME_BITS);
  assign frame_take = frame_end & frame_full;                            // short or long frames are dropped
  assign cmd_byte   = in_shift_reg[`LPD_CMD_MSB:`LPD_CMD_LSB];
  assign data_word  = in_shift_reg[`LPD_DATA_MSB:`LPD_DATA_LSB];

  // command decode
  assign wr_code    = frame_take & (cmd_byte == `LPD_CMD_WR_CODE);
  assign wr_mode    = frame_take & (cmd_byte == `LPD_CMD_WR_MODE);
  assign rd_code    = frame_take & (cmd_byte == `LPD_CMD_RD_CODE);
  assign rd_mode    = frame_take & (cmd_byte == `LPD_CMD_RD_MODE);
  assign rb_enabled = mode_reg[`LPD_NO_AUTO_RB_BIT];

  // whole 16-bit word stored as one field
  assign code_next = wr_code ? data_word : code_reg;

  // reserved bits 4..0 are not stored and read as zero
  assign mode_next = wr_mode ? (data_word & `LPD_MODE_LIVE_MASK) : mode_reg;

  // each taken frame sets what the next frame shifts out; the fault word is not modelled, so zeros
  assign rb_word_next = ~frame_take ? rb_word_reg :
                        (rd_code & rb_enabled) ? {cmd_byte, code_reg} :
                        (rd_mode & rb_enabled) ? {cmd_byte, mode_reg} :
                        `LPD_RB_RESET;

  // register file update, once per completed frame
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      code_reg    <= `LPD_CODE_RESET;
      mode_reg    <= `LPD_MODE_RESET;
      rb_word_reg <= `LPD_RB_RESET;
    end else begin
      code_reg    <= code_next;
      mode_reg    <= mode_next;
      rb_word_reg <= rb_word_next;
    end
  end

  // mode fields: watchdog select 15..13, enable 12, readback 11
  // alarm 10, min current 9, adc select 8, adc enable 7, ref down 6, loop alert 5
  // the analog side decodes these bits from o_mode_control directly
  assign o_mode_control   = mode_reg;
  assign o_converter_code = code_reg;
  assign o_range_active   = range_reg;

  // range change only re-maps; code_reg is never touched by it
  lpd_loop_map u_loop_map (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_code    (code_reg),
    .i_range   (lpd_pkg::lpd_range_e'(range_reg)),
    .o_current (o_loop_current_value)
  );

endmodule

//--- bench/lpd_core_monitor.sv
// checker for the loop converter register block
// assumes it is bound onto lpd_core, one i_clock domain
module lpd_core_monitor (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst,
  // watched ports
  input wire logic        i_frame_sel_n,
  input wire logic        o_serial_out,
  input wire logic [1:0]  i_range_sel,
  input wire logic [15:0] o_converter_code,
  input wire logic [15:0] o_mode_control,
  input wire logic [1:0]  o_range_active,
  input wire logic [24:0] o_loop_current_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] up_cnt_reg;
  // edges since reset, so history from inside reset is never trusted
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) up_cnt_reg <= 4'h0;
    else if (up_cnt_reg != 4'hf) up_cnt_reg <= up_cnt_reg + 4'h1;
  end
  // ideal current in nanoamps; range codes 2 and 3 are both wide
  function automatic logic [24:0] ideal(logic [15:0] c, logic [1:0] r);
    longint b, s;
    b = (r == 2'h0) ? 64'h3d_0900 : (r == 2'h1) ? 64'h39_fbc0 : 64'h30_d400;
    s = (r == 2'h0) ? 64'hf4_2400 : (r == 2'h1) ? 64'h106_7380 : 64'h13d_6200;
    return 25'(b + ((s * c) >> 16));
  endfunction
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_mode_reserved_zero: assert property (o_mode_control[4:0] == 5'h00)
    else $error("mode reserved bits set");
  a_current_map: assert property (up_cnt_reg > 4'h2 |-> o_loop_current_value == ideal($past(o_converter_code), $past(o_range_active)))
    else $error("loop current off mapping");
  a_current_span: assert property (up_cnt_reg > 4'h2 |-> o_loop_current_value >= 25'h30_d400 && o_loop_current_value < 25'h16e_3600)
    else $error("loop current out of span");
  a_code_quiet: assert property (!i_frame_sel_n [*5] |=> $stable(o_converter_code))
    else $error("code moved inside frame");
  a_mode_quiet: assert property (!i_frame_sel_n [*5] |=> $stable(o_mode_control))
    else $error("mode moved inside frame");
  a_code_after_frame: assert property ($changed(o_converter_code) |-> $past(i_frame_sel_n, 2))
    else $error("code changed without frame end");
  a_mode_after_frame: assert property ($changed(o_mode_control) |-> $past(i_frame_sel_n, 2))
    else $error("mode changed without frame end");
  a_range_follows: assert property ((up_cnt_reg == 4'hf && $stable(i_range_sel)) [*4] |-> o_range_active == i_range_sel)
    else $error("range not taken over");
  a_serial_idle: assert property (i_frame_sel_n && $past(i_frame_sel_n) |-> !o_serial_out)
    else $error("serial out busy between frames");
endmodule

bind lpd_core lpd_core_monitor i_mon (.i_clock(i_clock), .i_rst(i_rst), .i_frame_sel_n(i_frame_sel_n),
  .o_serial_out(o_serial_out), .i_range_sel(i_range_sel), .o_converter_code(o_converter_code),
  .o_mode_control(o_mode_control), .o_range_active(o_range_active), .o_loop_current_value(o_loop_current_value));

//--- bench/lpd_host.sv
// host side of the serial link: frames msb first, readback captured
// assumes only the bench calls frame() and nothing else drives these pins
module lpd_host (
  // serial link
  output logic            o_serial_clock,
  output logic            o_frame_sel_n,
  output logic            o_serial_out,
  input  wire logic       i_serial_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_serial_clock = 1'b0;
    o_frame_sel_n = 1'b1;
    o_serial_out = 1'b0;
  end
  // n bits, 12 ns clock only inside the frame, idle low
  task automatic frame(input int n, input logic [23:0] w, output logic [23:0] rd);
    rd = 24'h00_0000;
    o_frame_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #3 o_serial_out = w[i];  // data moves off the falling edge
      #3 o_serial_clock = 1'b1;
      #6 rd[i] = i_serial_in;  // readback bit stands up to the falling edge
      o_serial_clock = 1'b0;
    end
    #6 o_frame_sel_n = 1'b1;
    o_serial_out = ~o_serial_out;  // released line must not echo the last bit
    #30;  // select high for 6 core cycles, above the 4 needed
  endtask
endmodule

//--- bench/lpd_core_bench.sv
// self-checking bench for the loop converter register block
// assumes lpd_core, lpd_host and the bound monitor are compiled first
module lpd_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic        sclk, sel_n, serial_in, serial_out;
  logic [1:0]  range = 2'h0, ract;
  logic [15:0] code, mode, m_code = 16'h0000, m_mode = 16'h0000;
  logic [24:0] cur;
  logic [23:0] rd, exp_rb = 24'h00_0000;
  logic [15:0] pts[$] = '{16'h0000, 16'h0001, 16'h7fff, 16'h8000, 16'hfffe, 16'hffff};
  int          fails = 0, compares = 0, seed = 79168;
  always #2.5 i_clock = ~i_clock;
  lpd_core i_lpd_core (.i_clock(i_clock), .i_rst(i_rst), .i_serial_clock(sclk), .i_frame_sel_n(sel_n),
    .i_serial_in(serial_in), .o_serial_out(serial_out), .i_range_sel(range), .o_converter_code(code),
    .o_mode_control(mode), .o_range_active(ract), .o_loop_current_value(cur));
  lpd_host i_lpd_host (.o_serial_clock(sclk), .o_frame_sel_n(sel_n), .o_serial_out(serial_in), .i_serial_in(serial_out));
  // ideal current in nanoamps, floored
  function automatic logic [24:0] ideal(logic [15:0] c, logic [1:0] r);
    longint b, s;
    b = (r == 2'h0) ? 64'h3d_0900 : (r == 2'h1) ? 64'h39_fbc0 : 64'h30_d400;
    s = (r == 2'h0) ? 64'hf4_2400 : (r == 2'h1) ? 64'h106_7380 : 64'h13d_6200;
    return 25'(b + ((s * c) >> 16));
  endfunction
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one full frame; the model steps and readback, code, mode and current are compared
  task automatic xfer(input logic [23:0] w);
    i_lpd_host.frame(24, w, rd);
    chk(25'(rd), 25'(exp_rb));
    exp_rb = ((w[23:16] == 8'h81 || w[23:16] == 8'h82) && m_mode[11]) ?
             {w[23:16], (w[23:16] == 8'h81) ? m_code : m_mode} : 24'h00_0000;
    if (w[23:16] == 8'h01) m_code = w[15:0];
    if (w[23:16] == 8'h02) m_mode = w[15:0] & 16'hffe0;
    chk(25'(code), 25'(m_code));
    chk(25'(mode), 25'(m_mode));
    chk(cur, ideal(m_code, range));
  endtask
  initial begin
    #200_000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (20) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clock);
    xfer(24'h02_ffff);
    xfer(24'h82_0000);
    xfer(24'h09_0000);
    $display("test mode fields done");
    pts.push_back(16'($random(seed)));
    foreach (pts[i]) begin
      xfer({8'h01, pts[i]});
      for (int r = 0; r < 4; r++) begin
        @(negedge i_clock) range = 2'(r);
        xfer(24'h81_0000);
        xfer(24'h05_0000);
      end
    end
    $display("test codes and ranges done");
    i_lpd_host.frame(23, 24'h01_5a5a, rd);  // short frame dropped
    xfer(24'h09_0000);
    $display("test short frame done");
    xfer({8'h02, 16'($random(seed)) & 16'hf7ff});
    xfer(24'h81_0000);
    xfer(24'h09_0000);  // no readback without mode bit 11
    $display("test readback off done");
    wrap_up();
  end
endmodule
